// [sci_receiver_data_recovery_bench.sv]
// Purpose: self-checking bench of the serial receive data recovery block
// Assumes: baud divisor 3, so a tick every 4 pclk and a bit of 64 pclk
// Notes:   rows hold one character each; awkward cases follow the loop
module sci_receiver_data_recovery_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // signals and table
    localparam int LIMIT = 40000;
    typedef struct {
        logic [8:0] dat;
        logic       nine;
        logic       stp;
        int         gb;
        int         bclk;
        logic [3:0] st;
        logic [7:0] rd;
        logic       nin;
    } scirx_row_t;

    logic                      pclk       = 1'b0;
    logic                      presetn    = 1'b0;
    scirx_pkg::scirx_apb_req_t apb_req    = '0;
    scirx_pkg::scirx_apb_rsp_t apb_rsp;
    logic                      rxd;
    logic                      rx_irq;
    int                        num_errors = 0;
    int                        n_compared = 0;
    int                        cycles     = 0;
    // glitch index: -1 none, 0 start bit, nb+1 stop bit
    scirx_row_t rows [12] = '{
        '{9'h0a5, 1'b0, 1'b1, -1, 64, 4'h1, 8'ha5, 1'b1},
        '{9'h15a, 1'b1, 1'b1, -1, 64, 4'h1, 8'h5a, 1'b1},
        '{9'h03c, 1'b1, 1'b1, -1, 64, 4'h1, 8'h3c, 1'b0},
        '{9'h07e, 1'b0, 1'b1, -1, 64, 4'h1, 8'h7e, 1'b0},
        '{9'h055, 1'b0, 1'b1, 3, 64, 4'h3, 8'h55, 1'b0},
        '{9'h0c3, 1'b0, 1'b1, 0, 64, 4'h3, 8'hc3, 1'b1},
        '{9'h081, 1'b0, 1'b1, 9, 64, 4'h3, 8'h81, 1'b1},
        '{9'h0f0, 1'b0, 1'b0, -1, 64, 4'h5, 8'hf0, 1'b1},
        '{9'h000, 1'b0, 1'b0, -1, 64, 4'hd, 8'h00, 1'b0},
        '{9'h000, 1'b1, 1'b0, -1, 64, 4'hd, 8'h00, 1'b0},
        '{9'h055, 1'b0, 1'b1, -1, 62, 4'h1, 8'h55, 1'b0},
        '{9'h0aa, 1'b0, 1'b1, -1, 66, 4'h1, 8'haa, 1'b1}
    };

    always #2 pclk = ~pclk;

    scirx_top dut_u (
        .pclk    (pclk),
        .presetn (presetn),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp),
        .rxd     (rxd),
        .rx_irq  (rx_irq)
    );

    scirx_tx_model tx_u (
        .pclk (pclk),
        .rxd  (rxd)
    );

    // ======================================================================
    // tasks
    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            $display("unexpected %s: expected %h, seen %h", nm, x, g);
            num_errors++;
        end
    endtask

    // apb cycle: request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                     pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
    endtask

    // hang guard; short runs stay far below the ceiling
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            finish_test();
        end
    end

    // ======================================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        int          nb;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(scirx_pkg::OFS_CTRL_ONE, 32'h0, "ctrl_one");
        rd(scirx_pkg::OFS_CTRL_TWO, 32'h0, "ctrl_two");
        rd(scirx_pkg::OFS_STATUS, 32'h0, "status");
        rd(scirx_pkg::OFS_BAUD, 32'h0000000f, "baud");
        wr(scirx_pkg::OFS_BAUD, 32'h3);
        wr(scirx_pkg::OFS_CTRL_TWO, 32'h1);
        wr(scirx_pkg::OFS_DATA, 32'hff);
        rd(scirx_pkg::OFS_DATA, 32'h0, "data_ro");
        apb(1'b1, 12'h014, 32'h1, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        // character table
        foreach (rows[i]) begin
            nb = rows[i].nine ? 9 : 8;
            wr(scirx_pkg::OFS_CTRL_ONE, {30'h0, 1'b1, rows[i].nine});
            // start search needs three high ticks after enabling
            repeat (16) @(posedge pclk);
            fork
                tx_u.send(rows[i].dat, nb, rows[i].stp, rows[i].gb,
                          rows[i].bclk);
                begin
                    repeat (nb * 64 + 24) @(posedge pclk);
                    chk("irq_early", 32'h0, {31'h0, rx_irq});
                end
            join
            // slow data finishes its stop samples before the line frees
            repeat (48) @(posedge pclk);
            chk("irq", 32'h1, {31'h0, rx_irq});
            rd(scirx_pkg::OFS_STATUS, {28'h0, rows[i].st}, "status");
            rd(scirx_pkg::OFS_DATA, {24'h0, rows[i].rd}, "data");
            rd(scirx_pkg::OFS_CTRL_TWO, {30'h0, rows[i].nin, 1'b1}, "ninth");
            rd(scirx_pkg::OFS_STATUS, 32'h0, "cleared");
            chk("irq_off", 32'h0, {31'h0, rx_irq});
        end
        // start edge that fails verification, then a good character
        tx_u.pulse(8);
        repeat (200) @(posedge pclk);
        rd(scirx_pkg::OFS_STATUS, 32'h0, "false_start");
        tx_u.send(9'h03c, 8, 1'b1, -1, 64);
        repeat (48) @(posedge pclk);
        rd(scirx_pkg::OFS_STATUS, 32'h1, "after_false");
        rd(scirx_pkg::OFS_DATA, 32'h3c, "after_false_data");
        // masked request, then unmasked while full
        wr(scirx_pkg::OFS_CTRL_TWO, 32'h0);
        tx_u.send(9'h066, 8, 1'b1, -1, 64);
        repeat (48) @(posedge pclk);
        chk("irq_masked", 32'h0, {31'h0, rx_irq});
        wr(scirx_pkg::OFS_CTRL_TWO, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_unmask", 32'h1, {31'h0, rx_irq});
        wr(scirx_pkg::OFS_DATA, 32'hff);
        rd(scirx_pkg::OFS_STATUS, 32'h1, "status_arm");
        rd(scirx_pkg::OFS_DATA, 32'h66, "data_kept");
        // receiver disabled ignores the line
        wr(scirx_pkg::OFS_CTRL_ONE, 32'h0);
        tx_u.send(9'h05a, 8, 1'b1, -1, 64);
        repeat (48) @(posedge pclk);
        rd(scirx_pkg::OFS_STATUS, 32'h0, "disabled");
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk("unmapped_rd", 32'h1, {31'h0, e});
        chk("unmapped_dat", 32'h0, r);
        // second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("pready_rst", 32'h0, {31'h0, apb_rsp.pready});
        chk("pslverr_rst", 32'h0, {31'h0, apb_rsp.pslverr});
        presetn <= 1'b1;
        rd(scirx_pkg::OFS_CTRL_TWO, 32'h0, "ctrl_two_rst");
        rd(scirx_pkg::OFS_BAUD, 32'h0000000f, "baud_rst");
        finish_test();
    end
endmodule

// [scirx_pkg.sv]
// Purpose: constants and types of the serial receive data recovery block
// Assumes: 32-bit apb, one clock pclk, oversample tick made from pclk
// Notes:   all offsets are byte addresses of aligned words
//
// Overview of operation
// - A completed character's data goes to the buffer; receive-full is set.
// - Interrupt request is high while receive-full and its enable are set.
// - Receive buffer is read-only; bus writes never alter received data.
// - Serial input is sampled on a tick at sixteen times the baud rate.
// - Tick counter restarts aligned to each detected start edge.
// - Tick counter resyncs on a one-to-zero data transition in the character.
// - Start search: low sample after three highs, then count ticks to 16.
// - Start verified at ticks 3,5,7; one high sets noise; two fail.
// - Failed start verification resets the counter and restarts the search.
// - Data bit is majority of ticks 8,9,10; disagreement sets noise.
// - High start samples at 8,9,10 set noise but keep the start.
// - Stop bit majority zero sets framing error; disagreement sets noise.
// - Framing error is set in the same update as receive-full.
// - A break character, lacking a high stop bit, sets framing error.
// - Stop sampling ends 154 ticks (8-bit) or 170 (9-bit) after edge.
// - Character length is eight or nine bits, from control register one.
// - Ninth-bit field holds bit 8, or a copy of bit 7 in 8-bit mode.
// - A break clears buffer and ninth bit, sets receive-full and break.
package scirx_pkg;

    // ======================================================================
    // register map
    localparam logic [11:0] OFS_CTRL_ONE  = 12'h000;
    localparam logic [11:0] OFS_CTRL_TWO  = 12'h004;
    localparam logic [11:0] OFS_STATUS    = 12'h008;
    localparam logic [11:0] OFS_DATA      = 12'h00c;
    localparam logic [11:0] OFS_BAUD      = 12'h010;

    // control_reg_one fields
    localparam int B_NINE_MODE = 0;
    localparam int B_RX_ENABLE = 1;
    // control_reg_two fields
    localparam int B_IRQ_EN    = 0;
    localparam int B_NINTH     = 1;
    // status_reg_one fields
    localparam int B_FULL      = 0;
    localparam int B_NOISE     = 1;
    localparam int B_FRAME     = 2;
    localparam int B_BREAK     = 3;

    localparam logic [15:0] BAUD_RST = 16'h000f;

    // ======================================================================
    // oversample timing
    localparam logic [4:0] RT_LAST   = 5'h10;
    localparam logic [4:0] RT_SMP_A  = 5'h03;
    localparam logic [4:0] RT_SMP_B  = 5'h05;
    localparam logic [4:0] RT_SMP_C  = 5'h07;
    localparam logic [4:0] RT_MID_A  = 5'h08;
    localparam logic [4:0] RT_MID_B  = 5'h09;
    localparam logic [4:0] RT_MID_C  = 5'h0a;
    localparam logic [7:0] STOP_T8   = 8'h9a;
    localparam logic [7:0] STOP_T9   = 8'haa;

    // ======================================================================
    // types
    typedef enum logic [1:0] {
        SCIRX_IDLE  = 2'b00,
        SCIRX_START = 2'b01,
        SCIRX_DATA  = 2'b10,
        SCIRX_STOP  = 2'b11
    } scirx_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scirx_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scirx_apb_rsp_t;

endpackage

// [scirx_top.sv]
// Purpose: receive data recovery of an asynchronous nrz serial port
// Assumes: apb master on pclk; rxd pin asynchronous to pclk
// Notes:   zero-wait apb slave; tick period is (baud divisor + 1) pclks
module scirx_top #(
    parameter logic [15:0] BAUD_DIV_RST = scirx_pkg::BAUD_RST
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire scirx_pkg::scirx_apb_req_t apb_req,
    output      scirx_pkg::scirx_apb_rsp_t apb_rsp,
    input  wire logic                      rxd,
    output      logic                      rx_irq
);

    // ======================================================================
    // elaboration check
    if (BAUD_DIV_RST == 16'h0000) begin : g_chk
        $error("baud divisor reset value must be nonzero");
    end

    // ======================================================================
    // state
    typedef struct packed {
        logic [2:0]              sync;
        logic                    rxf;
        logic [15:0]             div_cnt;
        logic                    tick;
        scirx_pkg::scirx_state_t fsm;
        logic [4:0]              rt;
        logic [3:0]              bit_idx;
        logic [2:0]              hist;
        logic [2:0]              smp;
        logic [8:0]              shreg;
        logic                    nz;
        logic                    last_one;
        logic [7:0]              tcount;
        logic                    slipped;
        logic                    done;
        logic                    nine;
        logic                    rx_en;
        logic                    irq_en;
        logic                    ninth;
        logic                    full;
        logic                    noise;
        logic                    fe;
        logic                    brk;
        logic [7:0]              data;
        logic [15:0]             baud;
        logic                    armed;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    irq;
    } scirx_st_t;

    scirx_st_t q;
    scirx_st_t d;

    // ======================================================================
    // helpers
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic mixed3(input logic [2:0] v);
        mixed3 = (v != 3'b000) && (v != 3'b111);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == scirx_pkg::OFS_CTRL_ONE) ||
                 (a == scirx_pkg::OFS_CTRL_TWO) ||
                 (a == scirx_pkg::OFS_STATUS)   ||
                 (a == scirx_pkg::OFS_DATA)     ||
                 (a == scirx_pkg::OFS_BAUD);
    endfunction

    logic       s;
    logic [2:0] v;
    logic       setup;
    logic       acc;
    logic [3:0] last_idx;
    logic [4:0] rt_nxt;
    logic [31:0] rd;

    assign s        = q.rxf;
    assign v        = {q.smp[1:0], s};
    assign setup    = apb_req.psel & ~apb_req.penable;
    assign acc      = apb_req.psel & apb_req.penable & q.pready;
    assign last_idx = q.nine ? 4'h9 : 4'h8;
    assign rt_nxt   = (q.rt == scirx_pkg::RT_LAST) ? 5'h01
                                                   : q.rt + 5'h01;

    // ======================================================================
    // read mux, evaluated in the setup phase
    always_comb begin
        rd = 32'h0000_0000;
        case (apb_req.paddr)
            scirx_pkg::OFS_CTRL_ONE: begin
                rd[scirx_pkg::B_NINE_MODE] = q.nine;
                rd[scirx_pkg::B_RX_ENABLE] = q.rx_en;
            end
            scirx_pkg::OFS_CTRL_TWO: begin
                rd[scirx_pkg::B_IRQ_EN] = q.irq_en;
                rd[scirx_pkg::B_NINTH]  = q.ninth;
            end
            scirx_pkg::OFS_STATUS: begin
                rd[scirx_pkg::B_FULL]  = q.full;
                rd[scirx_pkg::B_NOISE] = q.noise;
                rd[scirx_pkg::B_FRAME] = q.fe;
                rd[scirx_pkg::B_BREAK] = q.brk;
            end
            scirx_pkg::OFS_DATA: rd[7:0]  = q.data;
            scirx_pkg::OFS_BAUD: rd[15:0] = q.baud;
            default: rd = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        d        = q;
        d.done   = 1'b0;
        d.pready = 1'b1;
        // three-stage pin sync; level only moves when stages 2 and 3 agree
        d.sync = {q.sync[1:0], rxd};
        if (q.sync[1] == q.sync[2]) begin
            d.rxf = q.sync[2];
        end

        // oversample tick divider
        d.tick = 1'b0;
        if (q.div_cnt >= q.baud) begin
            d.div_cnt = 16'h0000;
            d.tick    = 1'b1;
        end else begin
            d.div_cnt = q.div_cnt + 16'h0001;
        end

        // recovery state machine, advances on ticks only
        if (!q.rx_en) begin
            d.fsm  = scirx_pkg::SCIRX_IDLE;
            d.hist = 3'b000;
        end else if (q.tick) begin
            d.hist   = {q.hist[1:0], s};
            d.rt     = rt_nxt;
            d.tcount = q.tcount + 8'h01;
            // tick 10 is kept as well, so the stop vote never uses a
            // level taken one pclk after the sample point
            if (q.rt == scirx_pkg::RT_SMP_A || q.rt == scirx_pkg::RT_SMP_B ||
                q.rt == scirx_pkg::RT_SMP_C || q.rt == scirx_pkg::RT_MID_A ||
                q.rt == scirx_pkg::RT_MID_B ||
                q.rt == scirx_pkg::RT_MID_C) begin
                d.smp = {q.smp[1:0], s};
            end
            case (q.fsm)
                scirx_pkg::SCIRX_IDLE: begin
                    // falling edge after three highs: this tick is 1
                    if (q.hist == 3'b111 && !s) begin
                        d.fsm      = scirx_pkg::SCIRX_START;
                        d.rt       = 5'h02;
                        d.tcount   = 8'h02;
                        d.slipped  = 1'b0;
                        d.nz       = 1'b0;
                        d.bit_idx  = 4'h0;
                        d.shreg    = 9'h000;
                        d.last_one = 1'b0;
                    end
                end
                scirx_pkg::SCIRX_START: begin
                    if (q.rt == scirx_pkg::RT_SMP_C) begin
                        if (maj3(v)) begin
                            d.fsm  = scirx_pkg::SCIRX_IDLE;
                            d.rt   = 5'h00;
                            d.hist = 3'b000;
                        end else if (v != 3'b000) begin
                            d.nz = 1'b1;
                        end
                    end
                    // late highs never cancel a verified start
                    if (q.rt == scirx_pkg::RT_MID_C && v != 3'b000) begin
                        d.nz = 1'b1;
                    end
                    if (q.rt == scirx_pkg::RT_LAST) begin
                        d.fsm = scirx_pkg::SCIRX_DATA;
                    end
                end
                scirx_pkg::SCIRX_DATA: begin
                    if (q.rt == scirx_pkg::RT_MID_C) begin
                        d.shreg[q.bit_idx] = maj3(v);
                        d.last_one         = maj3(v);
                        d.nz               = q.nz | mixed3(v);
                        d.bit_idx          = q.bit_idx + 4'h1;
                    end
                    if (q.rt == scirx_pkg::RT_LAST && q.bit_idx == last_idx)
                    begin
                        d.fsm = scirx_pkg::SCIRX_STOP;
                    end
                end
                scirx_pkg::SCIRX_STOP: begin
                    if (q.rt == scirx_pkg::RT_MID_C) begin
                        d.done = 1'b1;
                        d.fsm  = scirx_pkg::SCIRX_IDLE;
                    end
                end
                default: d.fsm = scirx_pkg::SCIRX_IDLE;
            endcase
            // realign on a falling edge after a bit that recovered as one
            if ((q.fsm == scirx_pkg::SCIRX_DATA ||
                 q.fsm == scirx_pkg::SCIRX_STOP) &&
                q.last_one && q.hist[0] && !s &&
                (q.rt > scirx_pkg::RT_MID_C || q.rt < scirx_pkg::RT_MID_A))
            begin
                d.rt      = 5'h02;
                d.slipped = 1'b1;
            end
        end

        // apb setup phase: latch read data and error answer
        if (setup) begin
            d.prdata  = rd;
            d.pslverr = ~mapped(apb_req.paddr);
        end

        // apb access phase: writes and read side effects
        if (acc && apb_req.pwrite) begin
            case (apb_req.paddr)
                scirx_pkg::OFS_CTRL_ONE: begin
                    d.nine  = apb_req.pwdata[scirx_pkg::B_NINE_MODE];
                    d.rx_en = apb_req.pwdata[scirx_pkg::B_RX_ENABLE];
                end
                scirx_pkg::OFS_CTRL_TWO:
                    d.irq_en = apb_req.pwdata[scirx_pkg::B_IRQ_EN];
                scirx_pkg::OFS_BAUD: d.baud = apb_req.pwdata[15:0];
                default: d.baud = q.baud;
            endcase
        end
        if (acc && !apb_req.pwrite) begin
            if (apb_req.paddr == scirx_pkg::OFS_STATUS) begin
                d.armed = 1'b1;
            end
            if (apb_req.paddr == scirx_pkg::OFS_DATA && q.armed) begin
                d.armed = 1'b0;
                d.full  = 1'b0;
                d.noise = 1'b0;
                d.fe    = 1'b0;
                d.brk   = 1'b0;
            end
        end

        // completed character; applied last so a set beats a clear
        if (q.done) begin
            d.full  = 1'b1;
            d.fe    = ~maj3(q.smp);
            d.noise = q.nz | mixed3(q.smp);
            if (!maj3(q.smp) && q.shreg == 9'h000) begin
                d.data  = 8'h00;
                d.ninth = 1'b0;
                d.brk   = 1'b1;
            end else begin
                d.data  = q.shreg[7:0];
                d.ninth = q.nine ? q.shreg[8] : q.shreg[7];
            end
        end
        d.irq = d.full & d.irq_en;
    end

    // ======================================================================
    // registers; stop samples held in smp until done is applied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.sync   <= 3'b111;
            q.rxf    <= 1'b1;
            q.baud   <= BAUD_DIV_RST;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp.prdata  = q.prdata;
    assign apb_rsp.pready  = q.pready;
    assign apb_rsp.pslverr = q.pslverr;
    assign rx_irq          = q.irq;

    // ======================================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_edge;
        q.tick && q.rx_en && q.fsm == scirx_pkg::SCIRX_IDLE &&
        q.hist == 3'b111 && !s;
    endsequence

    sequence s_bad_start;
        q.tick && q.rx_en && q.fsm == scirx_pkg::SCIRX_START &&
        q.rt == scirx_pkg::RT_SMP_C && maj3(v);
    endsequence

    AST_IRQ_FOLLOWS: assert property (
        q.full && q.irq_en |-> rx_irq)
        else $error("irq low while full and enabled");

    AST_RO_BUFFER: assert property (
        acc && apb_req.pwrite && apb_req.paddr == scirx_pkg::OFS_DATA
        && !q.done |=> $stable(q.data))
        else $error("bus write changed receive buffer");

    AST_TICK_GATED: assert property (
        !q.tick |=> $stable(q.rt))
        else $error("tick counter moved without tick");

    AST_START_ALIGN: assert property (
        s_edge |=> q.fsm == scirx_pkg::SCIRX_START && q.rt == 5'h02)
        else $error("start edge not aligned");

    AST_START_FAIL: assert property (
        s_bad_start |=> q.fsm == scirx_pkg::SCIRX_IDLE && q.rt == 5'h00)
        else $error("failed start not abandoned");

    AST_FE_WITH_FULL: assert property (
        $rose(q.fe) |-> q.full && $past(q.done))
        else $error("framing error set apart from full");

    AST_STOP_TIME: assert property (
        q.done && !q.slipped |->
        $past(q.tcount) == (q.nine ? scirx_pkg::STOP_T9 : scirx_pkg::STOP_T8))
        else $error("stop sample at wrong tick");

    AST_BREAK: assert property (
        q.done && !maj3(q.smp) && q.shreg == 9'h000 |=>
        q.full && q.brk && q.fe && q.data == 8'h00 && !q.ninth)
        else $error("break not recorded");

    AST_NINTH: assert property (
        q.done && !q.nine && maj3(q.smp) |=> q.ninth == q.data[7])
        else $error("ninth bit not copy of bit seven");

    AST_START_NOISE: assert property (
        q.tick && q.rx_en && q.fsm == scirx_pkg::SCIRX_START &&
        q.rt == scirx_pkg::RT_SMP_C && !maj3(v) && v != 3'b000
        |=> q.nz)
        else $error("single high start sample did not mark noise");

    AST_FULL_LOAD: assert property (
        q.done && maj3(q.smp) |=>
        q.full && q.data == $past(q.shreg[7:0]))
        else $error("completed character not loaded into buffer");

endmodule

// [scirx_tx_model.sv]
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: bit time given in pclk cycles; line idles high (pull-up)
// Notes:   a glitch inverts pclk 32..35 of one bit, one tick sample at
//          a tick period of 4 pclk
module scirx_tx_model (
    input  wire logic pclk,
    output      logic rxd
);
    // ======================================================================
    // line driver
    initial rxd = 1'b1;

    // start, data lsb first, stop; bit index 0 is the start bit
    task automatic send(input logic [8:0] d, input int nb, input logic stp,
                        input int gb, input int bclk);
        logic lvl;
        for (int b = 0; b <= nb + 1; b++) begin
            lvl = (b == 0) ? 1'b0 : (b <= nb) ? d[b-1] : stp;
            for (int c = 0; c < bclk; c++) begin
                @(posedge pclk);
                rxd <= (b == gb && c >= 32 && c < 36) ? ~lvl : lvl;
            end
        end
        // released line returns to its pull-up level
        @(posedge pclk);
        rxd <= 1'b1;
    endtask

    // short low pulse: a start edge that cannot verify
    task automatic pulse(input int n);
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (n) @(posedge pclk);
        rxd <= 1'b1;
    endtask
endmodule
